// file: verilog/ipdt_map.svh
`ifndef IPDT_MAP_SVH
`define IPDT_MAP_SVH
// Register byte offsets
`define IPDT_OFF_CTRL       8'h00
`define IPDT_OFF_INPUTS     8'h04
`define IPDT_OFF_DIM_T      8'h08
`define IPDT_OFF_OFF_T      8'h0C
`define IPDT_OFF_LIGHT_T    8'h10
`define IPDT_OFF_SAVE_T     8'h14
`define IPDT_OFF_STBY_T     8'h18
`define IPDT_OFF_SAVE_WAKE  8'h1C
`define IPDT_OFF_STBY_WAKE  8'h20
`define IPDT_OFF_GONG_DLY   8'h24
`define IPDT_OFF_GONG_LEN   8'h28
`define IPDT_OFF_STATUS     8'h2C
`define IPDT_OFF_ARRIVE     8'h30
`define IPDT_OFF_FLOOR      8'h34
// Control bits
`define IPDT_CTRL_DIM_EN    0
`define IPDT_CTRL_OFF_EN    1
`define IPDT_CTRL_LIGHT_EN  2
`define IPDT_CTRL_SAVE_EN   3
`define IPDT_CTRL_STBY_EN   4
`define IPDT_CTRL_LANDPANEL 5
`define IPDT_CTRL_MASK_LO   8
// Input bits written by the piloting software
`define IPDT_IN_CALLS       0
`define IPDT_IN_CARPREF     1
`define IPDT_IN_DOORS_SHUT  2
`define IPDT_IN_GUEST       3
`define IPDT_IN_PRIO        4
`define IPDT_IN_SPECIAL     5
// Arrival register: bit0 pulse, bit1 up, bits 7:4 call type, bits 15:8 floor
`define IPDT_ARR_GO         0
`define IPDT_ARR_UP         1
`define IPDT_ARR_TYPE_LO    4
`define IPDT_ARR_FLOOR_LO   8
// Level codes sent on the bus
`define IPDT_LEVEL_NORMAL   4'h0
`define IPDT_LEVEL_SAVE     4'h4
`define IPDT_LEVEL_STBY     4'h6
// Timers tick once per millisecond
`define IPDT_CLK_HZ         40000000
`define IPDT_TICK_MS        1
`define IPDT_TICK_CYC       ((`IPDT_CLK_HZ / 1000) * `IPDT_TICK_MS)
`define IPDT_STBY_BLANK_MS  3000
`define IPDT_RESP_OKAY      2'h0
`define IPDT_RESP_SLVERR    2'h2
`endif

// file: verilog/ipdt_pkg.sv
package ipdt_pkg;
    typedef enum logic [1:0] {
        IPDT_DISP_ON  = 2'b00,
        IPDT_DISP_DIM = 2'b01,
        IPDT_DISP_OFF = 2'b10
    } ipdt_disp_e;
    typedef enum logic [1:0] {
        IPDT_GONG_IDLE  = 2'b00,
        IPDT_GONG_WAIT  = 2'b01,
        IPDT_GONG_PULSE = 2'b10
    } ipdt_gong_e;
    // Bus-facing outputs grouped together
    typedef struct packed {
        logic [7:0] floor_value;
        logic arrow_on;
        logic disp_dim_msg;
        logic disp_off_msg;
        logic car_light_off;
        logic main_light_off_ack;
        logic [3:0] level_code;
        logic energy_saving_ind;
        logic energy_standby_ind;
        logic gong_up;
        logic gong_down;
    } ipdt_bus_out_s;
endpackage

// file: verilog/ipdt_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Millisecond up-counter: runs while enabled, clears when not, flags expiry
module ipdt_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic run,
    input wire logic [31:0] period_ms,
    output logic expired
);
    logic [31:0] count_reg;

    // Count held at zero when not running so each idle period starts afresh
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            count_reg <= 32'h00000000;
        end else if (tick && count_reg < period_ms) begin
            count_reg <= count_reg + 32'h00000001;
        end
    end

    // Zero period expires as soon as the timer runs, so no special case here
    always_comb begin
        expired = run && (count_reg >= period_ms);
    end
endmodule
`default_nettype wire

// file: verilog/ipdt_top.sv
// Behaviour
// [R01] Dim timer expires before switch-off timer starts
// [R02] Standby blanks displays within three seconds; code keeps them lit while a keep-on request is set
// [R03] Preference, guest, priority, special keep displays
// [R04] Dim or blank sends floor value zero
// [R05] Also emit power-saving display messages
// [R06] Lanterns off through normal arrow signal
// [R07] Two light-off outputs: status and acknowledge
// [R08] Installation uses active-off light polarity
// [R09] Gong fires after delay past counting pulse
// [R10] Gong only for configured call types
// [R11] Gong pulse length equals configured duration; code ends the pulse one tick early
// [R12] Separate up/down; landing panel own floor
// [R13] Idle save period asserts saving output, code
// [R14] Idle standby period asserts standby output, code
// [R15] Saving wake-up timer after leaving saving
// [R16] Standby wake-up timer after leaving standby
// [R17] Distinct saving and standby indication outputs
// [R18] Energy-reduced flag and wake-up warning flag
// [R19] Idle means no calls, doors closed; code also needs no car preference
// [R20] Idle end clears timers, outputs, starts wake
`include "ipdt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ipdt_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] current_floor,
    output ipdt_pkg::ipdt_bus_out_s bus_out
);
    import ipdt_pkg::*;

    logic [31:0] ctrl_reg, inputs_reg, floor_cfg_reg;
    logic [31:0] tper_reg [0:8];
    logic [7:0] aw_addr_reg;
    logic aw_held_reg, w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic arrive_go;
    logic [31:0] arrive_data;
    logic [15:0] tick_cnt_reg;
    logic tick;
    logic idle, keep_on, standby_now;
    logic [4:0] run_t, exp_t;
    logic save_wake_run_reg, stby_wake_run_reg;
    logic save_wake_exp, stby_wake_exp;
    logic [12:0] blank_cnt_reg;
    ipdt_disp_e disp_reg;
    ipdt_gong_e gong_reg;
    logic [31:0] gong_cnt_reg;
    logic gong_up_reg;
    logic [3:0] level_reg;
    logic [31:0] rd_val;

    // Millisecond tick shared by every timer
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end
    assign tick = (tick_cnt_reg == 16'((`IPDT_TICK_CYC) - 1));

    // Idle: no calls or preference pending and doors closed
    assign idle = !inputs_reg[`IPDT_IN_CALLS] && !inputs_reg[`IPDT_IN_CARPREF]
                  && inputs_reg[`IPDT_IN_DOORS_SHUT]; // [R19]
    assign keep_on = inputs_reg[`IPDT_IN_CARPREF] || inputs_reg[`IPDT_IN_GUEST]
                     || inputs_reg[`IPDT_IN_PRIO] || inputs_reg[`IPDT_IN_SPECIAL]; // [R03]

    // Timer 0 dim, 1 display off, 2 light, 3 saving, 4 standby
    assign run_t[0] = idle && !keep_on && ctrl_reg[`IPDT_CTRL_DIM_EN];
    // With dimming enabled the off timer starts once the dim state stands, so only standby blanks without dimming first
    assign run_t[1] = idle && !keep_on && ctrl_reg[`IPDT_CTRL_OFF_EN]
                      && (!ctrl_reg[`IPDT_CTRL_DIM_EN] || disp_reg != IPDT_DISP_ON); // [R01]
    assign run_t[2] = idle && !keep_on && ctrl_reg[`IPDT_CTRL_LIGHT_EN];
    assign run_t[3] = idle && ctrl_reg[`IPDT_CTRL_SAVE_EN];
    assign run_t[4] = idle && ctrl_reg[`IPDT_CTRL_STBY_EN];

    // Leaving idle stops every run term, which clears the counters [R20]
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_idle
            ipdt_timer u_t (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(tick),
                .run(run_t[gi]),
                .period_ms(tper_reg[gi]),
                .expired(exp_t[gi])
            );
        end
    endgenerate
    assign standby_now = exp_t[4];

    // Wake-up timers: started when the level is left, run until expiry or until the level is entered again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            save_wake_run_reg <= 1'b0;
            stby_wake_run_reg <= 1'b0;
        end else begin
            if (level_reg == `IPDT_LEVEL_SAVE && !exp_t[3] && !standby_now) begin
                save_wake_run_reg <= 1'b1; // [R15]
            end else if (save_wake_exp || exp_t[3]) begin
                save_wake_run_reg <= 1'b0;
            end
            if (level_reg == `IPDT_LEVEL_STBY && !standby_now) begin
                stby_wake_run_reg <= 1'b1; // [R16]
            end else if (stby_wake_exp || standby_now) begin
                stby_wake_run_reg <= 1'b0;
            end
        end
    end
    ipdt_timer u_save_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .run(save_wake_run_reg),
        .period_ms(tper_reg[5]),
        .expired(save_wake_exp)
    );
    ipdt_timer u_stby_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .run(stby_wake_run_reg),
        .period_ms(tper_reg[6]),
        .expired(stby_wake_exp)
    );

    // Level selection; standby outranks saving
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_reg <= `IPDT_LEVEL_NORMAL;
        end else if (standby_now) begin
            level_reg <= `IPDT_LEVEL_STBY; // [R14]
        end else if (exp_t[3]) begin
            level_reg <= `IPDT_LEVEL_SAVE; // [R13]
        end else begin
            level_reg <= `IPDT_LEVEL_NORMAL; // [R20]
        end
    end

    // Display state; without a keep-on request standby blanks at once, well inside three seconds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disp_reg <= IPDT_DISP_ON;
        end else if (keep_on || !idle) begin
            disp_reg <= IPDT_DISP_ON; // [R03] [R20]
        end else if (standby_now || exp_t[1]) begin
            disp_reg <= IPDT_DISP_OFF; // [R02]
        end else if (exp_t[0]) begin
            disp_reg <= IPDT_DISP_DIM;
        end else begin
            disp_reg <= IPDT_DISP_ON;
        end
    end

    // Watchdog on the standby blank path, in ms since standby began
    always_ff @(posedge aclk) begin
        if (!aresetn || !standby_now) begin
            blank_cnt_reg <= 13'h0000;
        end else if (tick && blank_cnt_reg < 13'(`IPDT_STBY_BLANK_MS)) begin
            blank_cnt_reg <= blank_cnt_reg + 13'h0001;
        end
    end

    // Gong: delay after counting pulse, then pulse one tick shorter than the set length
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gong_reg <= IPDT_GONG_IDLE;
            gong_cnt_reg <= 32'h00000000;
            gong_up_reg <= 1'b0;
        end else begin
            unique case (gong_reg)
                IPDT_GONG_IDLE: begin
                    gong_cnt_reg <= 32'h00000000;
                    if (arrive_go
                        && |(arrive_data[`IPDT_ARR_TYPE_LO +: 4] & ctrl_reg[`IPDT_CTRL_MASK_LO +: 4]) // [R10]
                        && (!ctrl_reg[`IPDT_CTRL_LANDPANEL]
                            || arrive_data[`IPDT_ARR_FLOOR_LO +: 8] == floor_cfg_reg[7:0])) begin // [R12]
                        gong_up_reg <= arrive_data[`IPDT_ARR_UP];
                        gong_reg <= IPDT_GONG_WAIT; // [R09]
                    end
                end
                IPDT_GONG_WAIT: begin
                    if (gong_cnt_reg >= tper_reg[7]) begin
                        gong_cnt_reg <= 32'h00000000;
                        gong_reg <= IPDT_GONG_PULSE;
                    end else if (tick) begin
                        gong_cnt_reg <= gong_cnt_reg + 32'h00000001;
                    end
                end
                IPDT_GONG_PULSE: begin
                    if (gong_cnt_reg + 32'h00000001 >= tper_reg[8]) begin
                        gong_reg <= IPDT_GONG_IDLE; // [R11]
                    end else if (tick) begin
                        gong_cnt_reg <= gong_cnt_reg + 32'h00000001;
                    end
                end
                default: gong_reg <= IPDT_GONG_IDLE;
            endcase
        end
    end

    // Bus outputs, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_out <= '0;
        end else begin
            bus_out.floor_value <= (disp_reg == IPDT_DISP_ON) ? current_floor : 8'h00; // [R04]
            bus_out.disp_dim_msg <= (disp_reg == IPDT_DISP_DIM); // [R05]
            bus_out.disp_off_msg <= (disp_reg == IPDT_DISP_OFF);
            bus_out.arrow_on <= (disp_reg == IPDT_DISP_ON); // [R06]
            // Active-high means off, so a lost link leaves the cabin lit [R08]
            bus_out.car_light_off <= exp_t[2] || standby_now; // [R07]
            bus_out.main_light_off_ack <= exp_t[2] || standby_now; // [R07]
            bus_out.level_code <= level_reg;
            bus_out.energy_saving_ind <= (level_reg == `IPDT_LEVEL_SAVE); // [R17]
            bus_out.energy_standby_ind <= (level_reg == `IPDT_LEVEL_STBY); // [R17]
            bus_out.gong_up <= (gong_reg == IPDT_GONG_PULSE) && gong_up_reg; // [R12]
            bus_out.gong_down <= (gong_reg == IPDT_GONG_PULSE) && !gong_up_reg;
        end
    end

    // AXI4-Lite write: address and data held in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IPDT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_reg[1:0] == 2'b00 && aw_addr_reg <= `IPDT_OFF_FLOOR
                                && aw_addr_reg != `IPDT_OFF_STATUS) ? `IPDT_RESP_OKAY : `IPDT_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;

    // Commit happens on the cycle both halves are held
    wire do_wr = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign arrive_go = do_wr && aw_addr_reg == `IPDT_OFF_ARRIVE && w_data_reg[`IPDT_ARR_GO];
    assign arrive_data = w_data_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= 32'h00000000;
            inputs_reg <= 32'h00000000;
            floor_cfg_reg <= 32'h00000000;
            for (int i = 0; i < 9; i++) begin
                tper_reg[i] <= 32'h00000000;
            end
        end else if (do_wr) begin
            unique case (aw_addr_reg)
                `IPDT_OFF_CTRL: ctrl_reg <= (ctrl_reg & ~wmask) | (w_data_reg & wmask);
                `IPDT_OFF_INPUTS: inputs_reg <= (inputs_reg & ~wmask) | (w_data_reg & wmask);
                `IPDT_OFF_FLOOR: floor_cfg_reg <= (floor_cfg_reg & ~wmask) | (w_data_reg & wmask);
                default: begin
                    // Unaligned writes answer an error and must leave the periods alone
                    if (aw_addr_reg[1:0] == 2'b00
                        && aw_addr_reg >= `IPDT_OFF_DIM_T && aw_addr_reg <= `IPDT_OFF_GONG_LEN) begin
                        tper_reg[aw_addr_reg[5:2] - 4'h2] <=
                            (tper_reg[aw_addr_reg[5:2] - 4'h2] & ~wmask) | (w_data_reg & wmask);
                    end
                end
            endcase
        end
    end

    // Read mux; status shows level, flags and display state [R18]
    always_comb begin
        rd_val = 32'h00000000;
        case (s_axi_araddr)
            `IPDT_OFF_CTRL: rd_val = ctrl_reg;
            `IPDT_OFF_INPUTS: rd_val = inputs_reg;
            `IPDT_OFF_FLOOR: rd_val = floor_cfg_reg;
            `IPDT_OFF_STATUS: rd_val = {11'h000, blank_cnt_reg, 1'b0, disp_reg,
                                        (save_wake_run_reg || stby_wake_run_reg), // [R18]
                                        (level_reg != `IPDT_LEVEL_NORMAL), level_reg[2:0]}; // [R18]
            default: begin
                if (s_axi_araddr >= `IPDT_OFF_DIM_T && s_axi_araddr <= `IPDT_OFF_GONG_LEN) begin
                    rd_val = tper_reg[s_axi_araddr[5:2] - 4'h2];
                end
            end
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `IPDT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= `IPDT_OFF_FLOOR
                            && s_axi_araddr != `IPDT_OFF_ARRIVE) ? `IPDT_RESP_OKAY : `IPDT_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
endmodule
`default_nettype wire

// file: bench/ipdt_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the top-level ports for relations that must hold on every cycle
module ipdt_top_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0] current_floor,
    input wire ipdt_pkg::ipdt_bus_out_s bus_out
);
    import ipdt_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Display blanking, messages and lanterns
    chk_blank_floor: assert property (!bus_out.arrow_on |-> bus_out.floor_value == 8'h00)
        else $error("floor value not zero while blanked");
    chk_lit_floor: assert property (bus_out.arrow_on && $past(bus_out.arrow_on) && $stable(current_floor)
        |-> bus_out.floor_value == current_floor) else $error("lit display lost the floor");
    chk_off_msg: assert property (bus_out.disp_off_msg |-> !bus_out.arrow_on)
        else $error("arrows lit while displays off");
    chk_dim_first: assert property ($rose(bus_out.disp_off_msg) && bus_out.level_code != 4'h6
        |-> $past(bus_out.disp_dim_msg)) else $error("displays went off without dimming");
    chk_stby_blank: assert property ($rose(bus_out.energy_standby_ind) |-> ##[0:2] bus_out.disp_off_msg)
        else $error("standby left displays on");
    // Light outputs, energy levels and gong directions
    chk_light_pair: assert property (bus_out.car_light_off == bus_out.main_light_off_ack)
        else $error("light-off outputs disagree");
    chk_save_code: assert property (bus_out.energy_saving_ind
        |-> bus_out.level_code == 4'h4 && !bus_out.energy_standby_ind) else $error("saving code wrong");
    chk_stby_code: assert property (bus_out.energy_standby_ind |-> bus_out.level_code == 4'h6)
        else $error("standby code wrong");
    chk_gong_dir: assert property (!(bus_out.gong_up && bus_out.gong_down))
        else $error("both gong directions at once");
    // Bus answers stand until taken
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
bind ipdt_top ipdt_top_monitor u_mon (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .current_floor, .bus_out);
`default_nettype wire

// file: bench/ipdt_far_devices.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side cabin light and gong modules as passive listeners
module ipdt_far_devices (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ipdt_pkg::ipdt_bus_out_s bus_out,
    output int up_cnt,
    output int dn_cnt,
    output int pulse_len,
    output logic cabin_lit
);
    import ipdt_pkg::*;
    int run_len;
    logic prev_up;
    logic prev_dn;
    // Active-off wiring: a silent bus leaves the passengers in light
    assign cabin_lit = !bus_out.car_light_off;
    // Gong modules count rising edges and measure pulse length in cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_cnt <= 0;
            dn_cnt <= 0;
            pulse_len <= 0;
            run_len <= 0;
            prev_up <= 1'b0;
            prev_dn <= 1'b0;
        end else begin
            prev_up <= bus_out.gong_up;
            prev_dn <= bus_out.gong_down;
            if (bus_out.gong_up && !prev_up) up_cnt <= up_cnt + 1;
            if (bus_out.gong_down && !prev_dn) dn_cnt <= dn_cnt + 1;
            if (bus_out.gong_up || bus_out.gong_down) run_len <= run_len + 1;
            else if (run_len != 0) begin
                pulse_len <= run_len;
                run_len <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipdt_map.svh"
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t %s", $time, m); end end
module testbench;
    import ipdt_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, current_floor = 8'h01;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lit;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    ipdt_bus_out_s bus_out;
    int n_errors = 0, checks = 0, cycles = 0, far_up, far_dn, far_len;
    int nidle[3] = '{32'h0, 32'h5, 32'h6};
    int keep[3] = '{32'hC, 32'h14, 32'h24};
    ipdt_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .current_floor, .bus_out);
    ipdt_far_devices u_far (.aclk, .aresetn, .bus_out, .up_cnt(far_up), .dn_cnt(far_dn), .pulse_len(far_len),
        .cabin_lit(lit));
    // 40 MHz clock
    initial forever #12.5 aclk = ~aclk;
    // Watchdog: the standby wake wait alone takes one tick period
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            $display("[FAIL] %0t timeout", $time);
            final_report();
        end
    end
    task automatic final_report;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Ready is combinational, so it is sampled at the falling edge before the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_hit, w_hit, bv;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            bv = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
        end while (!bv);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic hit, rv;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            hit = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (hit) s_axi_arvalid <= 1'b0;
        end while (!rv);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Reference model with all periods zero: the settled state of every output
    function automatic ipdt_bus_out_s model(int c, int i, logic [7:0] f);
        ipdt_bus_out_s e;
        logic idle, quiet, stby, off, dim;
        idle = (i & 32'h3) == 0 && (i & 32'h4) != 0;
        quiet = idle && (i & 32'h38) == 0;
        stby = idle && c[4];
        off = stby || (quiet && c[1]);
        dim = !off && quiet && c[0];
        e = '0;
        e.floor_value = (off || dim) ? 8'h00 : f;
        e.arrow_on = !(off || dim);
        e.disp_dim_msg = dim;
        e.disp_off_msg = off;
        e.car_light_off = stby || (quiet && c[2]);
        e.main_light_off_ack = e.car_light_off;
        e.energy_standby_ind = stby;
        e.energy_saving_ind = idle && c[3] && !stby;
        e.level_code = stby ? 4'h6 : (e.energy_saving_ind ? 4'h4 : 4'h0);
        return e;
    endfunction
    // Apply a configuration, then wait boundedly for the outputs to settle on the model
    task automatic apply(input int c, input int i);
        ipdt_bus_out_s e, g;
        logic [1:0] r;
        int n;
        current_floor <= 8'h01 + 8'($urandom_range(254));
        wr(`IPDT_OFF_CTRL, c, 4'hF, r);
        wr(`IPDT_OFF_INPUTS, i, 4'hF, r);
        n = 0;
        do begin
            @(negedge aclk);
            e = model(c, i, current_floor);
            g = bus_out;
            if (e.disp_off_msg) g.disp_dim_msg = e.disp_dim_msg;
            n++;
            @(posedge aclk);
        end while (g !== e && n < 200);
        `CHK(g, e, "outputs differ from model")
        `CHK(lit, ~e.car_light_off, "cabin light state")
    endtask
    initial begin
        logic [31:0] d, g;
        logic [1:0] r;
        void'($urandom(25367));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // Readback, byte strobes and refused places
        d = $urandom;
        wr(`IPDT_OFF_DIM_T, d, 4'hF, r);
        wr(`IPDT_OFF_DIM_T, ~d, 4'h1, r);
        rd(`IPDT_OFF_DIM_T, g, r);
        `CHK(g, {d[31:8], ~d[7:0]}, "strobe readback")
        wr(8'h3C, d, 4'hF, r);
        `CHK(r, `IPDT_RESP_SLVERR, "unmapped write")
        rd(`IPDT_OFF_ARRIVE, g, r);
        `CHK(r, `IPDT_RESP_SLVERR, "write-only read")
        // Zero every period; wake timers get one tick so the warning stays visible
        for (int a = 8; a <= 32'h28; a += 4) wr(a[7:0], (a == 32'h1C || a == 32'h20) ? 32'h1 : 32'h0, 4'hF, r);
        $display("test registers done");
        // Doors open, calls or car preference: not idle, nothing powers down
        foreach (nidle[k]) apply(32'hF, nidle[k]);
        apply(32'hF, 32'h4);
        rd(`IPDT_OFF_STATUS, g, r);
        `CHK(g[3], 1'b1, "reduced flag")
        $display("test idle done");
        // Keep-on requests hold displays and light, saving still engages
        foreach (keep[k]) apply(32'hF, keep[k]);
        apply(32'hF, 32'h5);
        rd(`IPDT_OFF_STATUS, g, r);
        `CHK(g[4:3], 2'b10, "saving wake warning")
        $display("test keep-on done");
        // Standby displaces saving and blanks the displays at once
        apply(32'h1F, 32'h4);
        apply(32'h1F, 32'h1);
        rd(`IPDT_OFF_STATUS, g, r);
        `CHK(g[4:3], 2'b10, "standby wake warning")
        repeat (40000) @(posedge aclk);
        rd(`IPDT_OFF_STATUS, g, r);
        `CHK(g[4:3], 2'b00, "standby wake never ended")
        $display("test standby done");
        // Landing mode, own floor zero: unlisted up, listed up elsewhere, listed down here
        wr(`IPDT_OFF_CTRL, 32'h22F, 4'hF, r);
        wr(`IPDT_OFF_ARRIVE, {16'h0, current_floor, 8'h13}, 4'hF, r);
        wr(`IPDT_OFF_ARRIVE, {16'h0, current_floor, 8'h23}, 4'hF, r);
        wr(`IPDT_OFF_ARRIVE, {16'h0, 8'h00, 8'h21}, 4'hF, r);
        for (int n = 0; n < 60000 && far_dn == 0; n++) @(posedge aclk);
        repeat (4) @(posedge aclk);
        `CHK(far_up, 0, "unlisted call type rang")
        `CHK(far_dn, 1, "listed call type silent")
        `CHK(far_len, 1, "gong pulse length")
        $display("test gong done");
        final_report();
    end
endmodule
`default_nettype wire
